//--- pll_lpm_pkg.sv
package pll_lpm_pkg;
	// register byte offsets
	localparam logic [7:0] PLL_STS_OFF  = 8'h00;
	localparam logic [7:0] PLL_MULT_OFF = 8'h04;
	localparam logic [7:0] LOCK_PRD_OFF = 8'h08;
	localparam logic [7:0] LPM_CTRL_OFF = 8'h0c;
	localparam logic [7:0] INT_STS_OFF  = 8'h10;
	localparam logic [7:0] INT_MASK_OFF = 8'h14;
	// status register fields
	localparam int LOCK_BIT  = 0;
	localparam int PD_BIT    = 2;
	localparam int MCF_BIT   = 3;
	localparam int REARM_BIT = 4;
	// interrupt status fields
	localparam int INT_MISSING = 0;
	localparam int INT_LOCKED  = 1;
	localparam int INT_WAKE    = 2;
	localparam int NUM_INT     = 3;
	// reset values
	localparam logic [15:0]        LOCK_PRD_RST = 16'hffff;
	localparam logic               PD_RST       = 1'b0;
	localparam logic               LOCK_RST     = 1'b1;
	localparam logic [1:0]         LPM_RST      = 2'h0;
	localparam logic [NUM_INT-1:0] INT_MASK_RST = 3'h0;
	// low-power select codes
	localparam logic [1:0] LPM_STANDBY = 2'h1;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {SRC_PLL, SRC_REF_DIV2, SRC_LIMP} clk_src_t;
	typedef enum logic [1:0] {LP_RUN, LP_STANDBY, LP_HALT} lp_state_t;

	// clock enables handed to the clock tree
	typedef struct packed {
		logic osc;
		logic pll;
		logic cpu;
		logic sys;
	} clk_gate_t;

	// qualified wake sources
	typedef struct packed {
		logic gpio;
		logic wdog;
		logic dbg;
	} wake_t;
endpackage : pll_lpm_pkg

//--- pll_lpm_ctrl.sv
`timescale 1ns/1ns
module pll_lpm_ctrl #(
	parameter int MULT_W = 4
) (
	input  wire logic                  i_mclk,            // 100 MHz system clock
	input  wire logic                  i_nrst,            // external reset pin, async, low
	input  wire logic                  i_ref_tick,        // one pulse per reference osc cycle
	input  wire logic                  i_osc_missing,     // detector: oscillator lost
	input  wire logic                  i_auto_fallback,   // detector switched secondary to primary
	input  wire logic                  i_protected_we,    // protected-register write enable
	input  wire logic                  i_idle_exec,       // idle instruction executed
	input  wire pll_lpm_pkg::wake_t    i_wake,            // qualified wake sources
	input  wire logic                  i_axi_awvalid,     // write address valid
	input  wire logic [7:0]            i_axi_awaddr,      // write address
	input  wire logic                  i_axi_wvalid,      // write data valid
	input  wire logic [31:0]           i_axi_wdata,       // write data
	input  wire logic [3:0]            i_axi_wstrb,       // write byte strobes
	input  wire logic                  i_axi_bready,      // write response ready
	input  wire logic                  i_axi_arvalid,     // read address valid
	input  wire logic [7:0]            i_axi_araddr,      // read address
	input  wire logic                  i_axi_rready,      // read data ready
	output logic                       o_axi_awready,     // write address ready
	output logic                       o_axi_wready,      // write data ready
	output logic                       o_axi_bvalid,      // write response valid
	output logic [1:0]                 o_axi_bresp,       // write response
	output logic                       o_axi_arready,     // read address ready
	output logic                       o_axi_rvalid,      // read data valid
	output logic [31:0]                o_axi_rdata,       // read data
	output logic [1:0]                 o_axi_rresp,       // read response
	output pll_lpm_pkg::clk_gate_t     o_clk_gate,        // clock enables
	output pll_lpm_pkg::clk_src_t      o_cpu_clk_src,     // CPU clock source select
	output logic [MULT_W-1:0]          o_pll_mult,        // multiplier to the PLL
	output logic                       o_dev_reset,       // device reset pulse
	output logic                       o_jtag_clk_en,     // debug port clock enable
	output logic                       o_irq              // level interrupt
);
	// elaboration check: the read mux pads the multiplier into one word
	if (MULT_W < 1 || MULT_W > 16) begin : g_bad_mult_w
		$error("MULT_W must be 1 to 16");
	end

	// control and status state
	logic                      pll_power_down;
	logic                      missing_clock_flag;
	logic                      armed;
	logic                      limp;
	logic                      pll_lock_flag;
	logic                      locking;
	logic [15:0]               lock_count;
	logic [15:0]               pll_lock_wait_period;
	logic [1:0]                lowpower_ctrl;
	logic [pll_lpm_pkg::NUM_INT-1:0] int_sts;
	logic [pll_lpm_pkg::NUM_INT-1:0] int_mask;
	logic [7:0]                aw_addr;
	logic [31:0]               w_data;
	logic [3:0]                w_strb;
	pll_lpm_pkg::lp_state_t    lp_state;
	pll_lpm_pkg::lp_state_t    next_lp_state;

	// bus decode: a write fires once address and data are both held
	wire        wr_fire  = !o_axi_awready && !o_axi_wready && !o_axi_bvalid;
	wire [7:0]  wr_word  = {aw_addr[7:2], 2'b00};
	wire [7:0]  rd_word  = {i_axi_araddr[7:2], 2'b00};
	wire        rd_take  = i_axi_arvalid && o_axi_arready;
	wire        sel_sts  = wr_word == pll_lpm_pkg::PLL_STS_OFF;
	wire        sel_mult = wr_word == pll_lpm_pkg::PLL_MULT_OFF;
	wire        sel_prd  = wr_word == pll_lpm_pkg::LOCK_PRD_OFF;
	wire        sel_lpm  = wr_word == pll_lpm_pkg::LPM_CTRL_OFF;
	wire        sel_ist  = wr_word == pll_lpm_pkg::INT_STS_OFF;
	wire        sel_imk  = wr_word == pll_lpm_pkg::INT_MASK_OFF;
	wire        wr_hit   = sel_sts || sel_mult || sel_prd || sel_lpm || sel_ist || sel_imk;
	wire        wr_b0    = wr_fire && w_strb[0];
	wire        sts_wr   = wr_b0 && sel_sts;
	wire        mult_wr  = wr_b0 && sel_mult;
	wire        lpm_wr   = wr_b0 && sel_lpm;
	wire        imk_wr   = wr_b0 && sel_imk;
	wire        prd_wr   = wr_fire && sel_prd && (w_strb[1:0] != 2'h0);
	wire        rearm    = sts_wr && w_data[pll_lpm_pkg::REARM_BIT];

	// byte-lane merge of the lock period
	wire [15:0] prd_merge = {w_strb[1] ? w_data[15:8] : pll_lock_wait_period[15:8],
	                         w_strb[0] ? w_data[7:0]  : pll_lock_wait_period[7:0]};

	// events
	wire        miss_event = i_osc_missing && armed;
	wire        lock_done  = locking && (lock_count == 16'h0000) && !mult_wr;
	wire        wake_event = (lp_state != pll_lpm_pkg::LP_RUN) && (next_lp_state == pll_lpm_pkg::LP_RUN);
	wire [pll_lpm_pkg::NUM_INT-1:0] int_events = {wake_event, lock_done, miss_event};
	wire        ist_rd_clr = rd_take && (rd_word == pll_lpm_pkg::INT_STS_OFF);
	// hardware set wins over the read clear
	wire [pll_lpm_pkg::NUM_INT-1:0] next_int_sts  = (ist_rd_clr ? '0 : int_sts) | int_events;
	wire [pll_lpm_pkg::NUM_INT-1:0] next_int_mask = imk_wr ? w_data[pll_lpm_pkg::NUM_INT-1:0] : int_mask;

	// status word: re-arm bit and reserved bit 1 read as zero
	wire [31:0] sts_word = {27'h0, 1'b0, missing_clock_flag, pll_power_down, 1'b0, pll_lock_flag};

	// read mux, unmapped addresses answer with an error and zero data
	wire        rd_hit = (rd_word == pll_lpm_pkg::PLL_STS_OFF)  || (rd_word == pll_lpm_pkg::PLL_MULT_OFF) ||
	                     (rd_word == pll_lpm_pkg::LOCK_PRD_OFF) || (rd_word == pll_lpm_pkg::LPM_CTRL_OFF) ||
	                     (rd_word == pll_lpm_pkg::INT_STS_OFF)  || (rd_word == pll_lpm_pkg::INT_MASK_OFF);
	wire [31:0] rd_mux = (rd_word == pll_lpm_pkg::PLL_STS_OFF)  ? sts_word :
	                     (rd_word == pll_lpm_pkg::PLL_MULT_OFF) ? {{(32-MULT_W){1'b0}}, o_pll_mult} :
	                     (rd_word == pll_lpm_pkg::LOCK_PRD_OFF) ? {16'h0, pll_lock_wait_period} :
	                     (rd_word == pll_lpm_pkg::LPM_CTRL_OFF) ? {30'h0, lowpower_ctrl} :
	                     (rd_word == pll_lpm_pkg::INT_STS_OFF)  ? {29'h0, int_sts} :
	                     (rd_word == pll_lpm_pkg::INT_MASK_OFF) ? {29'h0, int_mask} : 32'h0;

	// low-power state machine
	always_comb begin
		next_lp_state = lp_state;
		unique case (lp_state)
			pll_lpm_pkg::LP_RUN: begin
				// idle entry
				// mode 00 is plain idle: nothing changes here
				if (i_idle_exec && lowpower_ctrl[1]) begin
					next_lp_state = pll_lpm_pkg::LP_HALT;
				end else if (i_idle_exec && lowpower_ctrl == pll_lpm_pkg::LPM_STANDBY) begin
					next_lp_state = pll_lpm_pkg::LP_STANDBY;
				end
			end
			pll_lpm_pkg::LP_STANDBY: begin
				if (i_wake.gpio || i_wake.wdog || i_wake.dbg) begin
					next_lp_state = pll_lpm_pkg::LP_RUN;
				end
			end
			pll_lpm_pkg::LP_HALT: begin
				// halt exits
				// watchdog is dead in halt, so it cannot wake
				if (i_wake.gpio || i_wake.dbg) begin
					next_lp_state = pll_lpm_pkg::LP_RUN;
				end
			end
			default: begin
				next_lp_state = pll_lpm_pkg::LP_RUN;
			end
		endcase
		if (o_dev_reset) begin
			next_lp_state = pll_lpm_pkg::LP_RUN;
		end
	end

	// clock enables follow the next state so outputs match the state register
	// gating
	wire next_pd = o_dev_reset ? pll_lpm_pkg::PD_RST :
	               (sts_wr ? w_data[pll_lpm_pkg::PD_BIT] : pll_power_down);
	wire pll_lpm_pkg::clk_gate_t next_gate = '{
		osc: next_lp_state != pll_lpm_pkg::LP_HALT,
		pll: !next_pd && (next_lp_state != pll_lpm_pkg::LP_HALT),
		cpu: next_lp_state == pll_lpm_pkg::LP_RUN,
		sys: next_lp_state == pll_lpm_pkg::LP_RUN
	};
	wire next_limp    = miss_event ? 1'b1 : ((i_auto_fallback || rearm) ? 1'b0 : limp);
	wire next_locking = mult_wr ? 1'b1 : (lock_done ? 1'b0 : locking);
	wire pll_lpm_pkg::clk_src_t next_src = next_limp ? pll_lpm_pkg::SRC_LIMP :
	                                       (next_locking ? pll_lpm_pkg::SRC_REF_DIV2 : pll_lpm_pkg::SRC_PLL);

	// AXI write channel handshake
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_axi_awready <= 1'b1;
			o_axi_wready  <= 1'b1;
			o_axi_bvalid  <= 1'b0;
			o_axi_bresp   <= pll_lpm_pkg::RESP_OKAY;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (i_axi_awvalid && o_axi_awready) begin
				o_axi_awready <= 1'b0;
				aw_addr       <= i_axi_awaddr;
			end
			if (i_axi_wvalid && o_axi_wready) begin
				o_axi_wready <= 1'b0;
				w_data       <= i_axi_wdata;
				w_strb       <= i_axi_wstrb;
			end
			if (wr_fire) begin
				o_axi_bvalid <= 1'b1;
				o_axi_bresp  <= wr_hit ? pll_lpm_pkg::RESP_OKAY : pll_lpm_pkg::RESP_SLVERR;
			end
			if (o_axi_bvalid && i_axi_bready) begin
				o_axi_bvalid  <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI read channel, one cycle from address to data
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_axi_arready <= 1'b1;
			o_axi_rvalid  <= 1'b0;
			o_axi_rdata   <= 32'h0000_0000;
			o_axi_rresp   <= pll_lpm_pkg::RESP_OKAY;
		end else if (rd_take) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid  <= 1'b1;
			o_axi_rdata   <= rd_mux;
			o_axi_rresp   <= rd_hit ? pll_lpm_pkg::RESP_OKAY : pll_lpm_pkg::RESP_SLVERR;
		end else if (o_axi_rvalid && i_axi_rready) begin
			o_axi_rvalid  <= 1'b0;
			o_axi_arready <= 1'b1;
		end
	end

	// missing-clock detector state; a new loss beats a same-cycle clear
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			missing_clock_flag <= 1'b0;
			armed              <= 1'b1;
			limp               <= 1'b0;
			o_dev_reset        <= 1'b0;
		end else begin
			o_dev_reset <= miss_event;
			limp        <= next_limp;
			if (miss_event) begin
				missing_clock_flag <= 1'b1;
				armed              <= 1'b0;
			end else if (i_auto_fallback || rearm) begin
				missing_clock_flag <= 1'b0;
				armed              <= 1'b1;
			end
		end
	end

	// software controls, cleared by the device reset as well as the pin, except the interrupt mask, which only the pin clears
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			pll_power_down <= pll_lpm_pkg::PD_RST;
			lowpower_ctrl  <= pll_lpm_pkg::LPM_RST;
			int_mask       <= pll_lpm_pkg::INT_MASK_RST;
			o_pll_mult     <= '0;
		end else begin
			pll_power_down <= next_pd;
			if (o_dev_reset) begin
				lowpower_ctrl <= pll_lpm_pkg::LPM_RST;
				o_pll_mult    <= '0;
			end else begin
				if (lpm_wr) begin
					lowpower_ctrl <= w_data[1:0];
				end
				if (mult_wr) begin
					o_pll_mult <= w_data[MULT_W-1:0];
				end
			end
			int_mask <= next_int_mask;
		end
	end

	// lock period: only the pin resets it, device reset leaves it alone
	// period register
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			pll_lock_wait_period <= pll_lpm_pkg::LOCK_PRD_RST;
		end else if (prd_wr && i_protected_we) begin
			pll_lock_wait_period <= prd_merge;
		end
	end

	// lock counter runs on reference ticks; period 0 locks on the next cycle
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			locking       <= 1'b0;
			lock_count    <= 16'h0000;
			pll_lock_flag <= pll_lpm_pkg::LOCK_RST;
		end else begin
			locking <= next_locking;
			if (mult_wr) begin
				lock_count    <= pll_lock_wait_period;
				pll_lock_flag <= 1'b0;
			end else if (lock_done) begin
				pll_lock_flag <= 1'b1;
			end else if (locking && i_ref_tick) begin
				lock_count <= lock_count - 16'h0001;
			end
		end
	end

	// state, clock outputs and interrupt
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			lp_state      <= pll_lpm_pkg::LP_RUN;
			o_clk_gate    <= '{osc: 1'b1, pll: 1'b1, cpu: 1'b1, sys: 1'b1};
			o_cpu_clk_src <= pll_lpm_pkg::SRC_PLL;
			o_jtag_clk_en <= 1'b0;
			int_sts       <= '0;
			o_irq         <= 1'b0;
		end else begin
			lp_state      <= next_lp_state;
			o_clk_gate    <= next_gate;
			o_cpu_clk_src <= next_src;
			o_jtag_clk_en <= 1'b1;
			int_sts       <= next_int_sts;
			o_irq         <= |(next_int_sts & next_int_mask);
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence s_lock_zero;
		locking && lock_count == 16'h0000 ##1 pll_lock_flag && !locking;
	endsequence

	property p_missing;
		miss_event |=> missing_clock_flag && o_dev_reset && o_cpu_clk_src == pll_lpm_pkg::SRC_LIMP;
	endproperty
	a_missing: assert property (p_missing) else $error("missing clock not handled");

	property p_fallback;
		i_auto_fallback && !i_osc_missing |=> !missing_clock_flag && armed;
	endproperty
	a_fallback: assert property (p_fallback) else $error("fallback did not re-arm");

	property p_pll_off;
		pll_power_down |-> !o_clk_gate.pll;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("pll powered while power-down set");

	property p_pd_hold;
		lp_state != pll_lpm_pkg::LP_RUN && pll_power_down && !sts_wr && !o_dev_reset |=> pll_power_down;
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("power-down lost in low-power mode");

	property p_lock_drop;
		mult_wr |=> !pll_lock_flag && locking && o_cpu_clk_src != pll_lpm_pkg::SRC_PLL;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock flag not dropped");

	property p_lock_count;
		locking && lock_count == 16'h0001 && i_ref_tick && !mult_wr |=> s_lock_zero;
	endproperty
	a_lock_count: assert property (p_lock_count) else $error("lock count did not finish");

	property p_protect;
		prd_wr && !i_protected_we |=> $stable(pll_lock_wait_period);
	endproperty
	a_protect: assert property (p_protect) else $error("lock period written unprotected");

	property p_halt;
		lp_state == pll_lpm_pkg::LP_HALT |-> !o_clk_gate.osc && !o_clk_gate.pll && !o_clk_gate.cpu && !o_clk_gate.sys;
	endproperty
	a_halt: assert property (p_halt) else $error("clock running in halt");

	property p_standby;
		lp_state == pll_lpm_pkg::LP_STANDBY |-> o_clk_gate.osc && !o_clk_gate.cpu && (o_clk_gate.pll == !pll_power_down);
	endproperty
	a_standby: assert property (p_standby) else $error("standby clocks wrong");

endmodule : pll_lpm_ctrl

//--- cpu_core_model.sv
`timescale 1ns/1ns
// core and reference oscillator as seen from the clock control block
module cpu_core_model #(
	parameter int TICK_DIV = 4 // mclk cycles per reference cycle
) (
	input  wire logic                   i_mclk,     // system clock
	input  wire logic                   i_nrst,     // external reset, low
	input  wire pll_lpm_pkg::clk_gate_t i_clk_gate, // clock enables from the block
	input  wire logic                   i_run_idle, // bench asks the core to run idle
	output logic                        o_ref_tick, // one pulse per reference cycle
	output logic                        o_idle_exec // idle instruction executed
);
	int div;

	// reference ticks; a stopped oscillator gives none, so halt freezes locking
	// oscillator stops in halt
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			div        <= 0;
			o_ref_tick <= 1'b0;
		end else begin
			div        <= (div == TICK_DIV - 1) ? 0 : div + 1;
			o_ref_tick <= i_clk_gate.osc && (div == TICK_DIV - 1);
		end
	end

	// a core whose clock is stopped cannot run the instruction
	// idle instruction issue
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_idle_exec <= 1'b0;
		end else begin
			o_idle_exec <= i_run_idle && i_clk_gate.cpu;
		end
	end
endmodule : cpu_core_model

//--- tb_pll_lpm_ctrl.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_pll_lpm_ctrl;
	logic                   i_mclk, i_nrst, protected_we, osc_missing, auto_fallback, run_idle;
	pll_lpm_pkg::wake_t     wake_in;
	logic                   awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]             awaddr, araddr;
	logic [31:0]            wdata, rdata, rd;
	logic [3:0]             wstrb, mult;
	logic                   awready, wready, bvalid, arready, rvalid;
	logic [1:0]             bresp, rresp, rsp;
	pll_lpm_pkg::clk_gate_t gate;
	pll_lpm_pkg::clk_src_t  src;
	logic                   dev_reset, jtag_en, irq, ref_tick, idle_exec;
	int                     num_errors, comparisons, cycles, lock_ticks, n;

	pll_lpm_ctrl #(.MULT_W(4)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ref_tick(ref_tick),
		.i_osc_missing(osc_missing), .i_auto_fallback(auto_fallback), .i_protected_we(protected_we),
		.i_idle_exec(idle_exec), .i_wake(wake_in), .i_axi_awvalid(awvalid), .i_axi_awaddr(awaddr),
		.i_axi_wvalid(wvalid), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_bready(bready),
		.i_axi_arvalid(arvalid), .i_axi_araddr(araddr), .i_axi_rready(rready), .o_axi_awready(awready),
		.o_axi_wready(wready), .o_axi_bvalid(bvalid), .o_axi_bresp(bresp), .o_axi_arready(arready),
		.o_axi_rvalid(rvalid), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_clk_gate(gate),
		.o_cpu_clk_src(src), .o_pll_mult(mult), .o_dev_reset(dev_reset), .o_jtag_clk_en(jtag_en), .o_irq(irq));
	cpu_core_model #(.TICK_DIV(4)) core (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_clk_gate(gate),
		.i_run_idle(run_idle), .o_ref_tick(ref_tick), .o_idle_exec(idle_exec));

	// 100 MHz clock
	always #5 i_mclk = ~i_mclk;

	// hang guard; also counts reference ticks seen while locking
	always @(posedge i_mclk) begin
		cycles++;
		if (src === pll_lpm_pkg::SRC_REF_DIV2 && ref_tick === 1'b1)
			lock_ticks++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done  = 1'b0;
		@(posedge i_mclk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge i_mclk);
			if (awvalid && awready === 1'b1) begin awvalid <= 1'b0; aw_done = 1'b1; end
			if (wvalid && wready === 1'b1) begin wvalid <= 1'b0; w_done = 1'b1; end
		end
		while (bvalid !== 1'b1) @(posedge i_mclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_mclk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		do @(posedge i_mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge i_mclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rdr

	// select a mode, then let the core run the idle instruction
	task automatic idle_then(input logic [31:0] mode);
		wr(pll_lpm_pkg::LPM_CTRL_OFF, mode, rsp);
		@(posedge i_mclk) run_idle <= 1'b1;
		@(posedge i_mclk) run_idle <= 1'b0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : idle_then

	task automatic wake(input pll_lpm_pkg::wake_t w);
		@(posedge i_mclk) wake_in <= w;
		repeat (4) @(posedge i_mclk);
		wake_in <= '0;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : wake

	// oscillator loss; device reset must pulse exactly once
	task automatic miss();
		@(posedge i_mclk) osc_missing <= 1'b1;
		@(posedge i_mclk) osc_missing <= 1'b0;
		#1 n = dev_reset;
		repeat (4) begin @(posedge i_mclk); #1 n += dev_reset; end
		`CHK(n, 1)
	endtask : miss

	initial begin
		{i_mclk, i_nrst, protected_we, osc_missing, auto_fallback, run_idle, wake_in} = '0;
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		repeat (8) @(posedge i_mclk);
		i_nrst <= 1'b1;
		@(posedge i_mclk) #1;
		`CHK(jtag_en, 1'b1)
		`CHK(gate, 4'hf)
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd, 32'h1)
		rdr(pll_lpm_pkg::LOCK_PRD_OFF, rd, rsp); `CHK(rd, 32'hffff)
		rdr(pll_lpm_pkg::INT_MASK_OFF, rd, rsp); `CHK(rd, 32'h0)
		wr(pll_lpm_pkg::LOCK_PRD_OFF, 32'h3, rsp); `CHK(rsp, pll_lpm_pkg::RESP_OKAY)
		rdr(pll_lpm_pkg::LOCK_PRD_OFF, rd, rsp); `CHK(rd, 32'hffff)
		protected_we <= 1'b1;
		wr(pll_lpm_pkg::LOCK_PRD_OFF, 32'h3, rsp);
		rdr(pll_lpm_pkg::LOCK_PRD_OFF, rd, rsp); `CHK(rd, 32'h3)
		// lock sequence with a short period and the lock interrupt unmasked
		wr(pll_lpm_pkg::INT_MASK_OFF, 32'h2, rsp);
		lock_ticks = 0;
		wr(pll_lpm_pkg::PLL_MULT_OFF, 32'h5, rsp);
		@(posedge i_mclk) #1;
		`CHK(src, pll_lpm_pkg::SRC_REF_DIV2)
		`CHK(mult, 4'h5)
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd, 32'h0)
		n = 0;
		while (src !== pll_lpm_pkg::SRC_PLL && n < 100) begin @(posedge i_mclk); n++; end
		#1 `CHK(lock_ticks, 3)
		repeat (2) @(posedge i_mclk);
		#1 `CHK(irq, 1'b1)
		rdr(pll_lpm_pkg::INT_STS_OFF, rd, rsp); `CHK(rd, 32'h2)
		repeat (2) @(posedge i_mclk);
		#1 `CHK(irq, 1'b0)
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd, 32'h1)
		// zero period: lock returns before a read can land
		wr(pll_lpm_pkg::LOCK_PRD_OFF, 32'h0, rsp);
		wr(pll_lpm_pkg::PLL_MULT_OFF, 32'h0, rsp);
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd, 32'h1)
		// the zero-period lock raised the unmasked lock bit again; clear it
		rdr(pll_lpm_pkg::INT_STS_OFF, rd, rsp); `CHK(rd, 32'h2)
		wr(pll_lpm_pkg::PLL_STS_OFF, 32'h4, rsp);
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd, 32'h5)
		#1 `CHK(gate, 4'hb)
		idle_then(32'h1); `CHK(gate, 4'h8)
		wake(3'h4); `CHK(gate, 4'hb)
		idle_then(32'h2); `CHK(gate, 4'h0)
		`CHK(jtag_en, 1'b1)
		wake(3'h2); `CHK(gate, 4'h0)
		wake(3'h1); `CHK(gate, 4'hb)
		`CHK(irq, 1'b0)
		idle_then(32'h0); `CHK(gate, 4'hb)
		// watchdog wakes standby, unlike halt
		idle_then(32'h1); `CHK(gate, 4'h8)
		wake(3'h2); `CHK(gate, 4'hb)
		// missing oscillator, automatic fallback, then software re-arm
		miss();
		`CHK(src, pll_lpm_pkg::SRC_LIMP)
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd & 32'h1c, 32'h8)
		rdr(pll_lpm_pkg::LOCK_PRD_OFF, rd, rsp); `CHK(rd, 32'h0)
		@(posedge i_mclk) auto_fallback <= 1'b1;
		@(posedge i_mclk) auto_fallback <= 1'b0;
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd & 32'h8, 32'h0)
		miss();
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd & 32'h8, 32'h8)
		wr(pll_lpm_pkg::PLL_STS_OFF, 32'h10, rsp);
		rdr(pll_lpm_pkg::PLL_STS_OFF, rd, rsp); `CHK(rd & 32'h18, 32'h0)
		rdr(pll_lpm_pkg::INT_STS_OFF, rd, rsp); `CHK(rd & 32'h5, 32'h5)
		// unmapped place
		rdr(8'h20, rd, rsp); `CHK(rsp, pll_lpm_pkg::RESP_SLVERR)
		`CHK(rd, 32'h0)
		wr(8'h20, 32'h1, rsp); `CHK(rsp, pll_lpm_pkg::RESP_SLVERR)
		// mid-run pin reset: only the pin brings the lock period back
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_nrst <= 1'b1;
		rdr(pll_lpm_pkg::LOCK_PRD_OFF, rd, rsp); `CHK(rd, 32'hffff)
		`CHK(jtag_en, 1'b1)
		finish_test();
	end
endmodule : tb_pll_lpm_ctrl
